// ===== pkg/epb_pkg.sv
// Functional notes
// - Leaf selector 09h starts page blocking
// - Only privilege level 0 may block
// - Address from page register plus data segment
// - Result code returned in accumulator
// - Misaligned page address gives general protection
// - Address outside store gives page fault
// - Clear flags and accumulator before page checks
// - Invalid page sets zero flag, invalid code
// - Unblockable type sets carry, control or other code
// - Already blocked sets carry, already-blocked code
// - Blockable unblocked page gets blocked, no error
// - Epoch-locked control page returns epoch code, retry
// - Concurrent page writer returns lock-failure code
// - Zero and carry flags only on stated cases; the code also sets the zero flag on epoch lock
// - Conflicting resource use gives general protection
// - Protected mode segment limit violation faults
// - Non-canonical address in 64-bit mode faults
package epb_pkg;
    localparam int unsigned AXI_AW       = 8;
    localparam int unsigned PAGES        = 8;
    localparam int unsigned IDX_W        = 3;
    localparam int unsigned PAGE_SHIFT   = 12;
    // Register byte offsets
    localparam logic [7:0] OFF_ACC       = 8'h00;
    localparam logic [7:0] OFF_PADDR_LO  = 8'h04;
    localparam logic [7:0] OFF_PADDR_HI  = 8'h08;
    localparam logic [7:0] OFF_CTRL      = 8'h0c;
    localparam logic [7:0] OFF_SEG_LIM   = 8'h10;
    localparam logic [7:0] OFF_SEG_BASE  = 8'h14;
    localparam logic [7:0] OFF_FLAGS     = 8'h18;
    localparam logic [7:0] OFF_FAULT     = 8'h1c;
    localparam logic [7:0] OFF_FADDR_LO  = 8'h20;
    localparam logic [7:0] OFF_FADDR_HI  = 8'h24;
    localparam logic [7:0] OFF_MAP       = 8'h28;
    localparam logic [7:0] OFF_IRQ_STAT  = 8'h2c;
    localparam logic [7:0] OFF_IRQ_EN    = 8'h30;
    localparam logic [7:0] OFF_IRQ_CLR   = 8'h34;
    // Control register fields
    localparam int unsigned CTRL_START   = 0;
    localparam int unsigned CTRL_CPL_LO  = 1;
    localparam int unsigned CTRL_MODE64  = 3;
    localparam int unsigned CTRL_PROT    = 4;
    // Map register fields
    localparam int unsigned MAP_VALID    = 8;
    localparam int unsigned MAP_TYPE_LO  = 9;
    localparam int unsigned MAP_BLOCKED  = 12;
    // Interrupt status bits
    localparam int unsigned IRQ_DONE     = 0;
    localparam int unsigned IRQ_GP       = 1;
    localparam int unsigned IRQ_PF       = 2;
    localparam int unsigned IRQ_W        = 3;
    // Protected store placement
    localparam logic [63:0] STORE_BASE   = 64'h0000_0000_8000_0000;
    localparam logic [63:0] STORE_END    = 64'h0000_0000_8000_8000;
    localparam logic [31:0] LEAF_BLOCK   = 32'h0000_0009;
    // Result codes
    localparam logic [31:0] CODE_NO_ERROR      = 32'h0000_0000;
    localparam logic [31:0] CODE_INVALID_PAGE  = 32'h0000_0005;
    localparam logic [31:0] CODE_CONTROL_PAGE  = 32'h0000_0006;
    localparam logic [31:0] CODE_NOT_BLOCKABLE = 32'h0000_0007;
    localparam logic [31:0] CODE_ALREADY_BLK   = 32'h0000_0008;
    localparam logic [31:0] CODE_EPOCH_LOCKED  = 32'h0000_0009;
    localparam logic [31:0] CODE_LOCK_FAILURE  = 32'h0000_000a;
    // Page types
    localparam logic [2:0] PT_CONTROL    = 3'h0;
    localparam logic [2:0] PT_THREAD     = 3'h1;
    localparam logic [2:0] PT_REGULAR    = 3'h2;
    localparam logic [2:0] PT_TRIMMED    = 3'h4;
    localparam logic [1:0] AXI_OKAY      = 2'h0;
    localparam logic [1:0] AXI_SLVERR    = 2'h2;
    typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_EXEC = 2'b10} epb_state_e;
endpackage

// ===== verilog/epb_page_block_unit.sv
// Implementation choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
module epb_page_block_unit (
    // Clock and reset
    input  wire logic                  ref_clk_i,
    input  wire logic                  rstn_i,
    // AXI4-Lite write address and data
    input  wire logic [7:0]            s_axi_awaddr_i,
    input  wire logic                  s_axi_awvalid_i,
    output logic                       s_axi_awready_o,
    input  wire logic [31:0]           s_axi_wdata_i,
    input  wire logic [3:0]            s_axi_wstrb_i,
    input  wire logic                  s_axi_wvalid_i,
    output logic                       s_axi_wready_o,
    // AXI4-Lite write response
    output logic [1:0]                 s_axi_bresp_o,
    output logic                       s_axi_bvalid_o,
    input  wire logic                  s_axi_bready_i,
    // AXI4-Lite read
    input  wire logic [7:0]            s_axi_araddr_i,
    input  wire logic                  s_axi_arvalid_i,
    output logic                       s_axi_arready_o,
    output logic [31:0]                s_axi_rdata_o,
    output logic [1:0]                 s_axi_rresp_o,
    output logic                       s_axi_rvalid_o,
    input  wire logic                  s_axi_rready_i,
    // Concurrency status from other operations
    input  wire logic                  epoch_lock_i,
    input  wire logic                  page_writer_busy_i,
    input  wire logic                  resource_conflict_i,
    // Status outputs
    output logic                       busy_o,
    output logic                       irq_o
);
    // Bus slave state
    logic                          aw_held_r, w_held_r;
    logic [7:0]                    aw_addr_r;
    logic [31:0]                   w_data_r;
    logic [3:0]                    w_strb_r;
    logic                          bvalid_r, arready_r, rvalid_r;
    logic [1:0]                    bresp_r, rresp_r;
    logic [31:0]                   rdata_r;
    // Software visible registers
    logic [31:0]                   acc_r;
    logic [63:0]                   paddr_r;
    logic [4:0]                    ctrl_r;
    logic [31:0]                   seg_lim_r, seg_base_r;
    logic                          zf_r, cf_r, gp_r, pf_r;
    logic [63:0]                   fault_addr_r;
    logic [epb_pkg::IDX_W-1:0]     map_idx_r;
    logic [epb_pkg::IRQ_W-1:0]     irq_stat_r, irq_en_r;
    logic                          irq_r;
    // Page map entries in flip-flops
    logic [epb_pkg::PAGES-1:0]     ent_valid_r, ent_blk_r;
    logic [2:0]                    ent_type_r [epb_pkg::PAGES];
    epb_pkg::epb_state_e           state_r;

    // Write accepted when both halves are held and no response pending
    wire        wr_fire = aw_held_r && w_held_r && !bvalid_r;
    wire [31:0] wmask   = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}},
                           {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
    wire [31:0] wmix_acc  = (acc_r & ~wmask) | (w_data_r & wmask);
    wire        wr_acc    = wr_fire && aw_addr_r == epb_pkg::OFF_ACC;
    wire        wr_plo    = wr_fire && aw_addr_r == epb_pkg::OFF_PADDR_LO;
    wire        wr_phi    = wr_fire && aw_addr_r == epb_pkg::OFF_PADDR_HI;
    wire        wr_ctrl   = wr_fire && aw_addr_r == epb_pkg::OFF_CTRL;
    wire        wr_lim    = wr_fire && aw_addr_r == epb_pkg::OFF_SEG_LIM;
    wire        wr_base   = wr_fire && aw_addr_r == epb_pkg::OFF_SEG_BASE;
    wire        wr_map    = wr_fire && aw_addr_r == epb_pkg::OFF_MAP;
    wire        wr_ien    = wr_fire && aw_addr_r == epb_pkg::OFF_IRQ_EN;
    wire        wr_iclr   = wr_fire && aw_addr_r == epb_pkg::OFF_IRQ_CLR;
    wire        wr_mapped = wr_acc || wr_plo || wr_phi || wr_ctrl || wr_lim ||
                            wr_base || wr_map || wr_ien || wr_iclr;
    wire        st_idle   = state_r == epb_pkg::ST_IDLE;
    wire        st_exec   = state_r == epb_pkg::ST_EXEC;
    // Start only for the blocking leaf; other selectors do nothing here
    wire        go_w      = wr_ctrl && w_data_r[epb_pkg::CTRL_START] && st_idle &&
                            acc_r == epb_pkg::LEAF_BLOCK;

    // Operand address: data segment base applied outside 64-bit mode, no override
    wire [63:0] lin  = ctrl_r[epb_pkg::CTRL_MODE64] ? paddr_r :
                       {32'h0000_0000, paddr_r[31:0] + seg_base_r};
    wire [epb_pkg::IDX_W-1:0] idx = lin[epb_pkg::PAGE_SHIFT +: epb_pkg::IDX_W];
    // Fault detection in priority order
    wire priv_bad  = ctrl_r[epb_pkg::CTRL_CPL_LO +: 2] != 2'h0;
    wire canon_bad = ctrl_r[epb_pkg::CTRL_MODE64] &&
                     !(&paddr_r[63:47] || ~|paddr_r[63:47]);
    wire lim_bad   = !ctrl_r[epb_pkg::CTRL_MODE64] && ctrl_r[epb_pkg::CTRL_PROT] &&
                     paddr_r[31:0] > seg_lim_r;
    wire align_bad = lin[epb_pkg::PAGE_SHIFT-1:0] != 12'h000;
    wire gp_early  = priv_bad || canon_bad || lim_bad || align_bad;
    wire pf_c      = !gp_early && (lin < epb_pkg::STORE_BASE ||
                     lin >= epb_pkg::STORE_END);
    wire gp_c      = gp_early || (!pf_c && resource_conflict_i);
    wire eval      = !gp_c && !pf_c;
    // Page state evaluation
    wire [2:0] ptype = ent_type_r[idx];
    wire blockable = ptype == epb_pkg::PT_REGULAR || ptype == epb_pkg::PT_THREAD ||
                     ptype == epb_pkg::PT_TRIMMED;
    wire do_epoch  = eval && epoch_lock_i;
    wire do_lock   = eval && !epoch_lock_i && page_writer_busy_i;
    wire do_state  = eval && !epoch_lock_i && !page_writer_busy_i;
    wire do_inv    = do_state && !ent_valid_r[idx];
    wire do_nblk   = do_state && ent_valid_r[idx] && !blockable;
    wire do_already = do_state && ent_valid_r[idx] && blockable && ent_blk_r[idx];
    wire do_block  = do_state && ent_valid_r[idx] && blockable && !ent_blk_r[idx];
    wire [31:0] code_c = do_epoch   ? epb_pkg::CODE_EPOCH_LOCKED :
                         do_lock    ? epb_pkg::CODE_LOCK_FAILURE :
                         do_inv     ? epb_pkg::CODE_INVALID_PAGE :
                         do_nblk    ? ((ptype == epb_pkg::PT_CONTROL) ?
                                       epb_pkg::CODE_CONTROL_PAGE :
                                       epb_pkg::CODE_NOT_BLOCKABLE) :
                         do_already ? epb_pkg::CODE_ALREADY_BLK :
                                      epb_pkg::CODE_NO_ERROR;
    wire done_ev  = st_exec;
    wire [epb_pkg::IRQ_W-1:0] ev = {st_exec && pf_c, st_exec && gp_c, done_ev};

    // Read data selection
    wire [31:0] map_rd = {19'h0_0000, ent_blk_r[map_idx_r], ent_type_r[map_idx_r],
                          ent_valid_r[map_idx_r], 5'h00, map_idx_r};
    wire [7:0]  ra = s_axi_araddr_i;
    wire        rd_hit = ra == epb_pkg::OFF_ACC || ra == epb_pkg::OFF_PADDR_LO ||
                         ra == epb_pkg::OFF_PADDR_HI || ra == epb_pkg::OFF_CTRL ||
                         ra == epb_pkg::OFF_SEG_LIM || ra == epb_pkg::OFF_SEG_BASE ||
                         ra == epb_pkg::OFF_FLAGS || ra == epb_pkg::OFF_FAULT ||
                         ra == epb_pkg::OFF_FADDR_LO || ra == epb_pkg::OFF_FADDR_HI ||
                         ra == epb_pkg::OFF_MAP || ra == epb_pkg::OFF_IRQ_STAT ||
                         ra == epb_pkg::OFF_IRQ_EN || ra == epb_pkg::OFF_IRQ_CLR;
    wire [31:0] rd_mux =
        ra == epb_pkg::OFF_ACC      ? acc_r :
        ra == epb_pkg::OFF_PADDR_LO ? paddr_r[31:0] :
        ra == epb_pkg::OFF_PADDR_HI ? paddr_r[63:32] :
        ra == epb_pkg::OFF_CTRL     ? {26'h000_0000, !st_idle, ctrl_r} :
        ra == epb_pkg::OFF_SEG_LIM  ? seg_lim_r :
        ra == epb_pkg::OFF_SEG_BASE ? seg_base_r :
        ra == epb_pkg::OFF_FLAGS    ? {30'h0000_0000, cf_r, zf_r} :
        ra == epb_pkg::OFF_FAULT    ? {30'h0000_0000, pf_r, gp_r} :
        ra == epb_pkg::OFF_FADDR_LO ? fault_addr_r[31:0] :
        ra == epb_pkg::OFF_FADDR_HI ? fault_addr_r[63:32] :
        ra == epb_pkg::OFF_MAP      ? map_rd :
        ra == epb_pkg::OFF_IRQ_STAT ? {29'h0000_0000, irq_stat_r} :
        ra == epb_pkg::OFF_IRQ_EN   ? {29'h0000_0000, irq_en_r} : 32'h0000_0000;
    wire rd_take = s_axi_arvalid_i && arready_r;

    // Write channel capture, either order
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r  <= 32'h0000_0000;
            w_strb_r  <= 4'h0;
            bvalid_r  <= 1'b0;
            bresp_r   <= epb_pkg::AXI_OKAY;
        end else begin
            if (s_axi_awvalid_i && !aw_held_r) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= {s_axi_awaddr_i[7:2], 2'b00};
            end
            if (s_axi_wvalid_i && !w_held_r) begin
                w_held_r <= 1'b1;
                w_data_r <= s_axi_wdata_i;
                w_strb_r <= s_axi_wstrb_i;
            end
            if (wr_fire) begin
                aw_held_r <= 1'b0;
                w_held_r  <= 1'b0;
                bvalid_r  <= 1'b1;
                bresp_r   <= wr_mapped ? epb_pkg::AXI_OKAY : epb_pkg::AXI_SLVERR;
            end else if (bvalid_r && s_axi_bready_i) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // Read channel, one cycle from address to data
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            arready_r <= 1'b1;
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h0000_0000;
            rresp_r   <= epb_pkg::AXI_OKAY;
        end else if (rd_take) begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b1;
            rdata_r   <= rd_mux;
            rresp_r   <= rd_hit ? epb_pkg::AXI_OKAY : epb_pkg::AXI_SLVERR;
        end else if (rvalid_r && s_axi_rready_i) begin
            rvalid_r  <= 1'b0;
            arready_r <= 1'b1;
        end
    end

    // Operand registers ignore software writes while running; map index and interrupt enable take them always
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            paddr_r    <= 64'h0000_0000_0000_0000;
            ctrl_r     <= 5'h00;
            seg_lim_r  <= 32'hffff_ffff;
            seg_base_r <= 32'h0000_0000;
            map_idx_r  <= '0;
            irq_en_r   <= '0;
        end else begin
            if (wr_plo && st_idle) paddr_r[31:0]  <= w_data_r;
            if (wr_phi && st_idle) paddr_r[63:32] <= w_data_r;
            if (wr_ctrl && st_idle) ctrl_r <= {w_data_r[4:1], 1'b0};
            if (wr_lim && st_idle) seg_lim_r <= w_data_r;
            if (wr_base && st_idle) seg_base_r <= w_data_r;
            if (wr_map) map_idx_r <= w_data_r[epb_pkg::IDX_W-1:0];
            if (wr_ien) irq_en_r <= w_data_r[epb_pkg::IRQ_W-1:0];
        end
    end

    // Sequencer: one execute cycle makes check and update indivisible
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            state_r <= epb_pkg::ST_IDLE;
        end else begin
            case (state_r)
                epb_pkg::ST_IDLE: if (go_w) state_r <= epb_pkg::ST_EXEC;
                epb_pkg::ST_EXEC: state_r <= epb_pkg::ST_IDLE;
                default:          state_r <= epb_pkg::ST_IDLE;
            endcase
        end
    end

    // Result, flags and faults; faults leave flags and accumulator alone
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            acc_r        <= 32'h0000_0000;
            zf_r         <= 1'b0;
            cf_r         <= 1'b0;
            gp_r         <= 1'b0;
            pf_r         <= 1'b0;
            fault_addr_r <= 64'h0000_0000_0000_0000;
        end else if (st_exec) begin
            gp_r <= gp_c;
            pf_r <= pf_c;
            if (pf_c) fault_addr_r <= lin;
            if (eval) begin
                acc_r <= code_c;
                zf_r  <= do_epoch || do_inv;
                cf_r  <= do_nblk || do_already;
            end
        end else if (wr_acc && st_idle) begin
            acc_r <= wmix_acc;
        end
    end

    // Page map: software loads entries, the operation sets blocked
    genvar g;
    generate
        for (g = 0; g < epb_pkg::PAGES; g++) begin : g_ent
            wire sw_hit = wr_map && w_data_r[epb_pkg::IDX_W-1:0] == g;
            wire op_hit = st_exec && do_block && idx == g;
            always_ff @(posedge ref_clk_i) begin
                if (!rstn_i) begin
                    ent_valid_r[g] <= 1'b0;
                    ent_blk_r[g]   <= 1'b0;
                    ent_type_r[g]  <= epb_pkg::PT_REGULAR;
                end else if (op_hit) begin
                    ent_blk_r[g] <= 1'b1;
                end else if (sw_hit && st_idle) begin
                    ent_valid_r[g] <= w_data_r[epb_pkg::MAP_VALID];
                    ent_type_r[g]  <= w_data_r[epb_pkg::MAP_TYPE_LO +: 3];
                    ent_blk_r[g]   <= w_data_r[epb_pkg::MAP_BLOCKED];
                end
            end
        end
    endgenerate

    // Sticky events; a new event beats a simultaneous clear
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            irq_stat_r <= '0;
            irq_r      <= 1'b0;
        end else begin
            irq_stat_r <= (irq_stat_r & ~(wr_iclr ? w_data_r[epb_pkg::IRQ_W-1:0] :
                          {epb_pkg::IRQ_W{1'b0}})) | ev;
            irq_r      <= |(irq_stat_r & irq_en_r);
        end
    end

    assign s_axi_awready_o = !aw_held_r;
    assign s_axi_wready_o  = !w_held_r;
    assign s_axi_bvalid_o  = bvalid_r;
    assign s_axi_bresp_o   = bresp_r;
    assign s_axi_arready_o = arready_r;
    assign s_axi_rvalid_o  = rvalid_r;
    assign s_axi_rdata_o   = rdata_r;
    assign s_axi_rresp_o   = rresp_r;
    assign busy_o          = st_exec;
    assign irq_o           = irq_r;

    // Checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);

    property p_leaf;
        wr_ctrl && w_data_r[epb_pkg::CTRL_START] && st_idle &&
            acc_r != epb_pkg::LEAF_BLOCK |=> st_idle;
    endproperty
    a_leaf: assert property (p_leaf) else $error("wrong leaf started");
    property p_priv;
        st_exec && priv_bad |=> gp_r && !pf_r && $stable(acc_r);
    endproperty
    a_priv: assert property (p_priv) else $error("privilege not enforced");
    property p_align;
        st_exec && align_bad |=> gp_r && $stable(ent_blk_r) && $stable(zf_r);
    endproperty
    a_align: assert property (p_align) else $error("misalign not faulted");
    property p_range;
        st_exec && pf_c |=> pf_r && !gp_r && fault_addr_r == $past(lin);
    endproperty
    a_range: assert property (p_range) else $error("page fault missing");
    property p_invalid;
        st_exec && do_inv |=> zf_r && !cf_r && acc_r == epb_pkg::CODE_INVALID_PAGE
            && $stable(ent_blk_r);
    endproperty
    a_invalid: assert property (p_invalid) else $error("invalid page result");
    property p_nblk;
        st_exec && do_nblk |=> cf_r && !zf_r && (acc_r == epb_pkg::CODE_CONTROL_PAGE ||
            acc_r == epb_pkg::CODE_NOT_BLOCKABLE);
    endproperty
    a_nblk: assert property (p_nblk) else $error("unblockable result");
    property p_already;
        st_exec && do_already |=> cf_r && acc_r == epb_pkg::CODE_ALREADY_BLK;
    endproperty
    a_already: assert property (p_already) else $error("already blocked result");
    property p_block;
        st_exec && do_block |=> ent_blk_r[$past(idx)] && !cf_r && !zf_r &&
            acc_r == epb_pkg::CODE_NO_ERROR ##1 st_idle;
    endproperty
    a_block: assert property (p_block) else $error("block not applied");
    property p_epoch;
        st_exec && do_epoch |=> zf_r && acc_r == epb_pkg::CODE_EPOCH_LOCKED;
    endproperty
    a_epoch: assert property (p_epoch) else $error("epoch lock result");
    property p_lock;
        st_exec && do_lock |=> !zf_r && !cf_r && acc_r == epb_pkg::CODE_LOCK_FAILURE;
    endproperty
    a_lock: assert property (p_lock) else $error("lock failure result");
    property p_irq;
        irq_stat_r[epb_pkg::IRQ_DONE] && irq_en_r[epb_pkg::IRQ_DONE] |=> irq_o;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not raised");
    // Late faults and atomicity; a fault must leave results untouched
    property p_conflict;
        st_exec && !gp_early && !pf_c && resource_conflict_i |=>
            gp_r && !pf_r && $stable(acc_r);
    endproperty
    a_conflict: assert property (p_conflict) else $error("conflict not faulted");
    property p_limit;
        st_exec && lim_bad |=> gp_r && $stable(zf_r) && $stable(cf_r);
    endproperty
    a_limit: assert property (p_limit) else $error("segment limit not faulted");
    property p_canon;
        st_exec && canon_bad |=> gp_r && $stable(ent_blk_r);
    endproperty
    a_canon: assert property (p_canon) else $error("non-canonical not faulted");
    property p_atomic;
        st_exec && !do_block |=> $stable(ent_blk_r) && $stable(ent_valid_r);
    endproperty
    a_atomic: assert property (p_atomic) else $error("entry changed without block");
    property p_busy;
        busy_o |=> !busy_o;
    endproperty
    a_busy: assert property (p_busy) else $error("execute longer than one cycle");
    c_inv: cover property (st_exec && do_inv);
    c_block: cover property (st_exec && do_block);
    c_already: cover property (st_exec && do_already);
    c_pf: cover property (st_exec && pf_c);
    c_gp: cover property (st_exec && gp_c);
endmodule

// ===== tb/tb_epb_page_block_unit.sv
`timescale 1ns/1ps
module tb_epb_page_block_unit;
    // Every design input is driven from the bench
    logic        ref_clk_i = 1'b0, rstn_i = 1'b0;
    logic [7:0]  s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
    logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o, v;
    logic [3:0]  s_axi_wstrb_i = 4'hf;
    logic        s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
    logic        s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0, s_axi_awready_o, s_axi_wready_o;
    logic        epoch_lock_i = 1'b0, page_writer_busy_i = 1'b0, resource_conflict_i = 1'b0;
    logic        s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o, busy_o, irq_o, bz;
    logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, br, rr;
    int          num_errors = 0, cmp_count = 0;

    epb_page_block_unit epb_page_block_unit_i (.*);

    // Clock, 4 ns period
    initial begin
        forever #2 ref_clk_i = ~ref_clk_i;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Address and data offered together; each dropped once taken
    // Ready lines stay high afterwards so no line is driven twice in one step
    // Busy is taken at the response edge, the cycle in which it stands
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= d;
        {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= 3'b111;
        do begin
            @(posedge ref_clk_i);
            if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
            if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
        end while (s_axi_bvalid_o !== 1'b1);
        br = s_axi_bresp_o;
        bz = busy_o;
    endtask

    task automatic rd(input logic [7:0] a);
        s_axi_araddr_i <= a;
        {s_axi_arvalid_i, s_axi_rready_i} <= 2'b11;
        do begin
            @(posedge ref_clk_i);
            if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
        end while (s_axi_rvalid_o !== 1'b1);
        v = s_axi_rdata_o;
        rr = s_axi_rresp_o;
    endtask

    // One blocking operation: load entry, operand, leaf, start; then read results
    task automatic run(input logic [31:0] m, input logic [63:0] p, input logic [31:0] c,
                       input logic [2:0] lk, input logic [31:0] ea, input logic [1:0] ef,
                       input logic [1:0] et, input logic [31:0] em);
        {epoch_lock_i, page_writer_busy_i, resource_conflict_i} <= lk;
        wr(epb_pkg::OFF_MAP, m);
        wr(epb_pkg::OFF_PADDR_LO, p[31:0]);
        wr(epb_pkg::OFF_PADDR_HI, p[63:32]);
        wr(epb_pkg::OFF_ACC, epb_pkg::LEAF_BLOCK);
        wr(epb_pkg::OFF_CTRL, c);
        chk({31'h0, bz}, 32'h1);
        repeat (3) @(posedge ref_clk_i);
        rd(epb_pkg::OFF_FAULT);
        chk({30'h0, v[1:0]}, {30'h0, et});
        if (et == 2'h0) begin
            rd(epb_pkg::OFF_ACC);
            chk(v, ea);
            rd(epb_pkg::OFF_FLAGS);
            chk({30'h0, v[1:0]}, {30'h0, ef});
        end else if (et == 2'h2) begin
            rd(epb_pkg::OFF_FADDR_LO);
            chk(v, p[31:0]);
        end
        rd(epb_pkg::OFF_MAP);
        chk(v & 32'h0000_1f00, em);
        rd(epb_pkg::OFF_IRQ_STAT);
        chk(v, {29'h0, et, 1'b1});
        chk({31'h0, irq_o}, 32'h1);
        wr(epb_pkg::OFF_IRQ_CLR, 32'h7);
        repeat (2) @(posedge ref_clk_i);
        chk({31'h0, irq_o}, 32'h0);
        $display("Test done: entry %h operand %h control %h", m, p, c);
    endtask

    task automatic finish_test;
        $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // Watchdog, far beyond the under one thousand cycles the tests need
    initial begin
        #40000;
        num_errors++;
        finish_test;
    end

    initial begin
        repeat (3) @(posedge ref_clk_i);
        rstn_i <= 1'b1;
        rd(epb_pkg::OFF_SEG_LIM);
        chk(v, 32'hffff_ffff);
        wr(8'h3c, 32'h1);
        chk({30'h0, br}, {30'h0, epb_pkg::AXI_SLVERR});
        rd(8'h3c);
        chk({rr, v[29:0]}, {epb_pkg::AXI_SLVERR, 30'h0});
        wr(epb_pkg::OFF_IRQ_EN, 32'h7);
        wr(epb_pkg::OFF_ACC, 32'h0000_0008);
        wr(epb_pkg::OFF_CTRL, 32'h0000_0001);
        chk({31'h0, bz}, 32'h0);
        rd(epb_pkg::OFF_ACC);
        chk(v, 32'h0000_0008);
        run(32'h500, 64'h8000_0000, 32'h1, 3'h0, 32'h0, 2'h0, 2'h0, 32'h1500);
        run(32'h1500, 64'h8000_0000, 32'h1, 3'h0, 32'h8, 2'h2, 2'h0, 32'h1500);
        run(32'h301, 64'h8000_1000, 32'h1, 3'h0, 32'h0, 2'h0, 2'h0, 32'h1300);
        run(32'h902, 64'h8000_2000, 32'h1, 3'h0, 32'h0, 2'h0, 2'h0, 32'h1900);
        run(32'h403, 64'h8000_3000, 32'h1, 3'h0, 32'h5, 2'h1, 2'h0, 32'h400);
        run(32'h104, 64'h8000_4000, 32'h1, 3'h0, 32'h6, 2'h2, 2'h0, 32'h100);
        run(32'h705, 64'h8000_5000, 32'h1, 3'h0, 32'h7, 2'h2, 2'h0, 32'h700);
        run(32'h506, 64'h8000_6000, 32'h1, 3'h4, 32'h9, 2'h1, 2'h0, 32'h500);
        run(32'h507, 64'h8000_7000, 32'h1, 3'h2, 32'ha, 2'h0, 2'h0, 32'h500);
        run(32'h500, 64'h8000_0000, 32'h1, 3'h1, 32'h0, 2'h0, 2'h1, 32'h500);
        run(32'h500, 64'h8000_0800, 32'h1, 3'h0, 32'h0, 2'h0, 2'h1, 32'h500);
        run(32'h500, 64'h8000_8000, 32'h1, 3'h0, 32'h0, 2'h0, 2'h2, 32'h500);
        run(32'h500, 64'h8000_0000, 32'h3, 3'h0, 32'h0, 2'h0, 2'h1, 32'h500);
        run(32'h500, 64'h8000_8000_0000, 32'h9, 3'h0, 32'h0, 2'h0, 2'h1, 32'h500);
        wr(epb_pkg::OFF_SEG_BASE, 32'h0000_1000);
        run(32'h501, 64'h8000_0000, 32'h1, 3'h0, 32'h0, 2'h0, 2'h0, 32'h1500);
        wr(epb_pkg::OFF_SEG_LIM, 32'h7fff_ffff);
        run(32'h500, 64'h8000_0000, 32'h11, 3'h0, 32'h0, 2'h0, 2'h1, 32'h500);
        finish_test;
    end
endmodule
